// ==== hdl/sarf_pkg.sv ====
`default_nettype none
package sarf_pkg;
    localparam int          CODE_W     = 16;      // result width
    localparam int          CNT_W      = 5;       // falling-edge counter width
    localparam logic [4:0]  FALL_FIRST = 5'h01;   // conversion starts
    localparam logic [4:0]  FALL_LEAD  = 5'h02;   // leading zero, driver on
    localparam logic [4:0]  FALL_MSB   = 5'h03;   // first result bit
    localparam logic [4:0]  FALL_LAST  = 5'h12;   // lsb, back to acquisition
    localparam logic [4:0]  CNT_RST    = 5'h00;
    localparam logic [15:0] CODE_MAX   = 16'h7FFF;
    localparam logic [15:0] CODE_MIN   = 16'h8000;
    localparam logic [15:0] CODE_RST   = 16'h0000;
    localparam logic        FRAME_IDLE = 1'b1;    // frame line level at reset
    localparam logic        SCLK_IDLE  = 1'b0;    // serial clock level at reset
    localparam int          SYNC_DEPTH = 3;       // shift flip-flops per pin input, before the level flop

    typedef enum logic [1:0] {
        ST_ACQ  = 2'h0,
        ST_WAIT = 2'h1,
        ST_CONV = 2'h3,
        ST_DONE = 2'h2
    } sarf_state_t;
endpackage : sarf_pkg
`default_nettype wire

// ==== hdl/sarf_sync.sv ====
`default_nettype none
module sarf_sync
    import sarf_pkg::*;
#(
    parameter logic RST_VAL = 1'b0   // level assumed during reset
) (
    input  wire logic clk_sys,       // system clock
    input  wire logic rst,           // async reset, active high
    input  wire logic pin,           // asynchronous pin level
    output logic      lvl            // filtered level
);
    logic [SYNC_DEPTH-1:0] sh_q;
    logic [SYNC_DEPTH-1:0] sh_d;
    logic                  lvl_q;
    logic                  lvl_d;

    // stage 1 feeds stage 2 only; level moves once stages 2 and 3 agree
    always_comb begin
        sh_d  = {sh_q[SYNC_DEPTH-2:0], pin};
        lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sh_q  <= {SYNC_DEPTH{RST_VAL}};
            lvl_q <= RST_VAL;
        end else begin
            sh_q  <= sh_d;
            lvl_q <= lvl_d;
        end
    end

    assign lvl = lvl_q;
endmodule : sarf_sync
`default_nettype wire

// ==== hdl/sarf_fifo.sv ====
`default_nettype none
module sarf_fifo
    import sarf_pkg::*;
#(
    parameter int WIDTH = 18,        // word width
    parameter int DEPTH = 32         // words
) (
    input  wire logic             clk_sys,    // system clock
    input  wire logic             rst,        // async reset, active high
    input  wire logic [WIDTH-1:0] in_data,    // write word
    input  wire logic             in_valid,   // write request
    output logic                  in_ready,   // space available, registered
    output logic [WIDTH-1:0]      out_data,   // head word
    output logic                  out_valid,  // head valid
    input  wire logic             out_ready   // drain side takes head
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("sarf_fifo: DEPTH must be at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    wr_d;
    logic [PW-1:0]    rd_q;
    logic [PW-1:0]    rd_d;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    logic             rdy_q;
    logic             rdy_d;
    logic             push;
    logic             pop;

    always_comb begin
        push  = in_valid && rdy_q;
        pop   = out_valid && out_ready;
        wr_d  = wr_q;
        rd_d  = rd_q;
        if (push) begin
            wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        cnt_d = cnt_q + CW'(push) - CW'(pop);
        rdy_d = (cnt_d != CW'(DEPTH));
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    assign in_ready  = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
endmodule : sarf_fifo
`default_nettype wire

// ==== hdl/sarf_readout.sv ====
// What this block does, and what its host must do
// RL1 - frame opens on select low, closes high
// RL2 - output floats idle and first period
// RL3 - sample at select fall, convert 17 periods
// RL4 - 18th falling edge enters acquisition
// RL5 - select falls, clock high: wait falling edge
// RL6 - select falls, clock low: counts edge one
// RL7 - simultaneous falls still start conversion
// RL8 - host avoids select fall at rising edge
// RL9 - select high keeps acquisition mode
// RL10 - one conversion per select assertion
// RL11 - output bits change on falling edges
// RL12 - edge two zero, edges 3-18 result
// RL13 - result is two's complement
// RL14 - clip to 7FFF and 8000
// RL15 - driver on edge two, off select rise
// RL16 - early select rise aborts and floats
// RL17 - host latches bits on rising edges; sarf_host records each bit at the end of the high half instead
// RL18 - host waits acquisition interval between frames
// RL19 - input tracked between conversions
// RL20 - bits belong to current conversion
// RL21 - host assembles signed word msb first
`default_nettype none
module sarf_readout
    import sarf_pkg::*;
#(
    parameter int IN_W  = 18,        // width of the signed input word
    parameter int DEPTH = 32         // input FIFO depth
) (
    input  wire logic            clk_sys,     // system clock, 20 MHz
    input  wire logic            rst,         // async reset, active high
    input  wire logic            frame_n,     // frame select pin, active low
    input  wire logic            sclk,        // serial clock pin
    input  wire logic [IN_W-1:0] diff_in,     // signed differential input word
    input  wire logic            diff_valid,  // input word offered
    output logic                 diff_ready,  // input word accepted
    output logic                 sdo_o,       // serial result out
    output logic                 sdo_oe,      // serial result driver enable
    output logic                 acq_mode,    // low-power acquisition
    output logic                 conv_busy,   // conversion running
    output logic                 clip,        // held sample was clipped
    output logic                 abort_pulse  // frame ended early
);
    generate
        if (IN_W < CODE_W) begin : g_bad
            $error("sarf_readout: IN_W below result width");
        end
    endgenerate

    // saturate wide input to the signed result range
    function automatic logic [CODE_W:0] sarf_clamp(input logic [IN_W-1:0] v);
        logic neg;
        logic all1;
        logic any1;
        neg  = v[IN_W-1];
        all1 = &v[IN_W-1:CODE_W-1];
        any1 = |v[IN_W-1:CODE_W-1];
        if (!neg && any1) begin
            sarf_clamp = {1'b1, CODE_MAX}; // RL14
        end else if (neg && !all1) begin
            sarf_clamp = {1'b1, CODE_MIN}; // RL14
        end else begin
            sarf_clamp = {1'b0, v[CODE_W-1:0]}; // RL13
        end
    endfunction : sarf_clamp

    logic              cs_lvl;
    logic              sclk_lvl;
    logic              cs_prev_q;
    logic              sclk_prev_q;
    logic              cs_fall;
    logic              cs_rise;
    logic              sclk_fall;
    logic [IN_W-1:0]   fifo_data;
    logic              fifo_valid;
    logic              trk_pop;
    logic [CODE_W:0]   trk_clamp;
    logic              acq_q;
    logic              acq_d;
    logic              cs_prev_d;
    logic              sclk_prev_d;

    sarf_sync #(
        .RST_VAL (FRAME_IDLE)
    ) u_sync_cs (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (frame_n),
        .lvl     (cs_lvl)
    );

    sarf_sync #(
        .RST_VAL (SCLK_IDLE)
    ) u_sync_sclk (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (sclk),
        .lvl     (sclk_lvl)
    );

    sarf_fifo #(
        .WIDTH (IN_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_data   (diff_in),
        .in_valid  (diff_valid),
        .in_ready  (diff_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (acq_q)
    );

    // pin edges, both seen with equal latency
    always_comb begin
        cs_prev_d   = cs_lvl;
        sclk_prev_d = sclk_lvl;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cs_prev_q   <= FRAME_IDLE;
            sclk_prev_q <= SCLK_IDLE;
        end else begin
            cs_prev_q   <= cs_prev_d;
            sclk_prev_q <= sclk_prev_d;
        end
    end

    assign cs_fall   = cs_prev_q && !cs_lvl;   // RL1
    assign cs_rise   = !cs_prev_q && cs_lvl;   // RL1
    assign sclk_fall = sclk_prev_q && !sclk_lvl;

    sarf_state_t       state_q;
    sarf_state_t       state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic [CODE_W-1:0] track_q;
    logic [CODE_W-1:0] track_d;
    logic              trk_clip_q;
    logic              trk_clip_d;
    logic [CODE_W-1:0] hold_q;
    logic [CODE_W-1:0] hold_d;
    logic              clip_q;
    logic              clip_d;
    logic              oe_q;
    logic              oe_d;
    logic              sdo_q;
    logic              sdo_d;
    logic              busy_q;
    logic              busy_d;
    logic              abort_q;
    logic              abort_d;

    assign trk_pop   = fifo_valid && acq_q;   // RL19
    assign trk_clamp = sarf_clamp(fifo_data);

    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        track_d    = track_q;
        trk_clip_d = trk_clip_q;
        hold_d     = hold_q;
        clip_d     = clip_q;
        oe_d       = oe_q;
        sdo_d      = sdo_q;
        acq_d      = acq_q;
        busy_d     = busy_q;
        abort_d    = 1'b0;
        // tracking only while in acquisition
        if (trk_pop) begin
            track_d    = trk_clamp[CODE_W-1:0]; // RL19
            trk_clip_d = trk_clamp[CODE_W];
        end
        if (cs_lvl) begin
            // idle or aborted frame: float and stay in acquisition
            state_d = ST_ACQ;   // RL9
            cnt_d   = CNT_RST;
            oe_d    = 1'b0;     // RL2 RL15 RL16
            sdo_d   = 1'b0;
            acq_d   = 1'b1;     // RL9
            busy_d  = 1'b0;
            abort_d = cs_rise && (state_q == ST_WAIT || state_q == ST_CONV); // RL16
        end else if (cs_fall) begin
            hold_d = track_q;   // RL3
            clip_d = trk_clip_q;
            acq_d  = 1'b0;
            busy_d = 1'b1;
            if (sclk_lvl) begin
                state_d = ST_WAIT;    // RL5
                cnt_d   = CNT_RST;
            end else begin
                state_d = ST_CONV;    // RL6 RL7
                cnt_d   = FALL_FIRST; // RL6
            end
        end else if (sclk_fall) begin
            case (state_q)
                ST_WAIT: begin
                    state_d = ST_CONV;    // RL5
                    cnt_d   = FALL_FIRST;
                end
                ST_CONV: begin
                    cnt_d = cnt_q + 1'b1; // RL3
                    oe_d  = 1'b1;         // RL15
                    if (cnt_d == FALL_LEAD) begin
                        sdo_d = 1'b0;     // RL12
                    end else begin
                        sdo_d = hold_q[4'(FALL_LAST - cnt_d)]; // RL11 RL12 RL20
                    end
                    if (cnt_d == FALL_LAST) begin
                        state_d = ST_DONE; // RL4
                        acq_d   = 1'b1;    // RL4
                        busy_d  = 1'b0;
                    end
                end
                default: begin
                    state_d = state_q;     // RL10
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q    <= ST_ACQ;
            cnt_q      <= CNT_RST;
            track_q    <= CODE_RST;
            trk_clip_q <= 1'b0;
            hold_q     <= CODE_RST;
            clip_q     <= 1'b0;
            oe_q       <= 1'b0;
            sdo_q      <= 1'b0;
            acq_q      <= 1'b1;
            busy_q     <= 1'b0;
            abort_q    <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            track_q    <= track_d;
            trk_clip_q <= trk_clip_d;
            hold_q     <= hold_d;
            clip_q     <= clip_d;
            oe_q       <= oe_d;
            sdo_q      <= sdo_d;
            acq_q      <= acq_d;
            busy_q     <= busy_d;
            abort_q    <= abort_d;
        end
    end

    assign sdo_o       = sdo_q;
    assign sdo_oe      = oe_q;
    assign acq_mode    = acq_q;
    assign conv_busy   = busy_q;
    assign clip        = clip_q;
    assign abort_pulse = abort_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_open_low;
        cs_fall && !sclk_lvl;
    endsequence

    sequence s_last_fall;
        state_q == ST_CONV && cnt_q == FALL_LAST - 5'h01 && sclk_fall && !cs_lvl;
    endsequence

    sequence s_second_fall;
        state_q == ST_CONV && cnt_q == FALL_FIRST && sclk_fall && !cs_lvl;
    endsequence

    a_idle_float: assert property (cs_lvl |=> !sdo_oe && acq_mode) // RL2
        else $error("driver on or not in acquisition while frame idle");

    a_first_float: assert property (state_q == ST_CONV && cnt_q == FALL_FIRST |-> !sdo_oe) // RL2
        else $error("driver on during first serial period");

    a_lead_zero: assert property (state_q == ST_CONV && cnt_q == FALL_LEAD |-> sdo_oe && !sdo_o) // RL12
        else $error("no leading zero on second falling edge");

    a_msb_third: assert property (state_q == ST_CONV && cnt_q == FALL_MSB |-> sdo_o == hold_q[CODE_W-1]) // RL12
        else $error("msb not presented on third falling edge");

    a_low_start: assert property (s_open_low |=> state_q == ST_CONV && cnt_q == FALL_FIRST) // RL6
        else $error("select fall with clock low did not count edge one");

    a_high_wait: assert property (cs_fall && sclk_lvl |=> state_q == ST_WAIT && cnt_q == CNT_RST) // RL5
        else $error("select fall with clock high did not wait");

    a_sample_take: assert property (cs_fall |=> hold_q == $past(track_q) && !acq_mode) // RL3
        else $error("sample not taken at select fall");

    a_acq_enter: assert property (s_last_fall |=> state_q == ST_DONE && acq_mode && sdo_o == hold_q[0]) // RL4
        else $error("no acquisition after eighteenth falling edge");

    a_abort_float: assert property ($rose(cs_lvl) && busy_q |=> // RL16
        !sdo_oe && state_q == ST_ACQ && abort_q ##1 !abort_q)
        else $error("early frame end did not abort");

    a_fall_update: assert property (!cs_lvl && !$past(cs_lvl) && !sclk_fall |=> $stable(sdo_o)) // RL11
        else $error("output bit changed without a falling edge");

    a_one_conv: assert property (state_q == ST_DONE && !cs_lvl |=> state_q == ST_DONE) // RL10
        else $error("second conversion without new frame");

    a_driver_on: assert property (s_second_fall |=> sdo_oe && cnt_q == FALL_LEAD) // RL15
        else $error("driver not enabled on second falling edge");

    a_drive_rest: assert property (state_q == ST_DONE && !cs_lvl |=> sdo_oe) // RL15
        else $error("driver released before frame end");

    a_clip_take: assert property (cs_fall |=> clip == $past(trk_clip_q)) // RL14
        else $error("clip flag not taken with the sample");

    a_busy_start: assert property (cs_fall |=> conv_busy) // RL3
        else $error("conversion not started at select fall");

    a_hold_still: assert property (!cs_fall |=> $stable(hold_q)) // RL3
        else $error("held sample changed inside a frame");

    a_edge_step: assert property (state_q == ST_CONV && sclk_fall && !cs_lvl |=> cnt_q == $past(cnt_q) + 5'h01) // RL3
        else $error("falling edge not counted once");

    a_wait_hold: assert property (state_q == ST_WAIT && !sclk_fall && !cs_lvl |=> state_q == ST_WAIT) // RL5
        else $error("wait left without a falling edge");

    a_idle_edges: assert property (cs_lvl && sclk_fall |=> state_q == ST_ACQ && !conv_busy) // RL9
        else $error("clock edge acted on while frame idle");

    a_last_busy: assert property (s_last_fall |=> !conv_busy) // RL4
        else $error("busy still set after eighteenth falling edge");

    a_abort_once: assert property (abort_pulse |=> !abort_pulse) // RL16
        else $error("abort pulse longer than one cycle");

    a_track_still: assert property (!acq_mode |=> $stable(track_q)) // RL19
        else $error("tracked sample moved outside acquisition");

    a_track_load: assert property (trk_pop |=> track_q == $past(trk_clamp[CODE_W-1:0])) // RL19
        else $error("drained word not tracked");
endmodule : sarf_readout
`default_nettype wire

// ==== verif/sarf_host.sv ====
`default_nettype none
module sarf_host
    import sarf_pkg::*;
#(
    parameter int HALF     = 4,  // clk_sys cycles per sclk half period
    parameter int ACQ_HALF = 2   // acquisition_interval in sclk halves
) (
    input  wire logic clk_sys,   // system clock
    output logic      frame_n,   // frame select, active low
    output logic      sclk,      // serial clock; outside frames only wiggle and run's setup and return steps move it
    input  wire logic sdo_o,     // result bit
    input  wire logic sdo_oe,    // result driver enable
    input  wire logic acq_mode,  // acquisition flag
    input  wire logic clip       // saturation flag
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [18:1] rec_bit;
    logic [18:1] rec_oe;
    logic [18:1] rec_acq;
    logic [15:0] rec_word;
    logic        rec_clip;
    logic        oe_after;
    logic        line_q = 1'h0;

    initial begin
        frame_n = FRAME_IDLE;
        sclk    = SCLK_IDLE;
    end

    task automatic half;
        repeat (HALF) @(posedge clk_sys);
        #1;
    endtask : half

    // a floated line shows the inverse of its last level
    task automatic record(input int k);
        line_q     = sdo_oe ? sdo_o : ~line_q;
        rec_bit[k] = line_q;
        rec_oe[k]  = sdo_oe;
        rec_acq[k] = acq_mode;
    endtask : record

    // mode 0: select falls with sclk high, 1: sclk low, 2: both fall together
    task automatic run(input int mode, input int n);
        sclk = (mode != 1);
        half();
        frame_n = 1'h0;
        if (mode == 2) sclk = 1'h0;
        if (mode == 0) half();
        for (int k = 1; k <= n; k++) begin
            if (k > 1 || mode == 0) sclk = 1'h0;
            half();
            sclk = 1'h1;
            half();
            record(k);
        end
        for (int j = 0; j < 16; j++) begin
            rec_word[15-j] = rec_bit[3+j];
        end
        rec_clip = clip;
        frame_n  = 1'h1;
        half();
        // driver release lags the pin by five edges
        @(posedge clk_sys);
        #1;
        oe_after = sdo_oe;
        sclk     = SCLK_IDLE;
        repeat (ACQ_HALF) half();
    endtask : run

    // clock activity while deselected
    task automatic wiggle(input int n);
        repeat (n) begin
            sclk = ~sclk;
            half();
        end
        sclk = SCLK_IDLE;
    endtask : wiggle
endmodule : sarf_host
`default_nettype wire

// ==== verif/sarf_readout_tb.sv ====
`default_nettype none
module sarf_readout_tb
    import sarf_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    localparam int LIMIT = 6000;

    typedef struct packed {
        logic [17:0] din;
        logic [1:0]  mode;
        logic [15:0] code;
        logic        clp;
    } sarf_row_t;

    sarf_row_t rows [7] = '{
        '{18'h00123, 2'h1, 16'h0123, 1'h0},
        '{18'h3FFFF, 2'h0, 16'hFFFF, 1'h0},
        '{18'h07FFF, 2'h2, 16'h7FFF, 1'h0},
        '{18'h08000, 2'h1, 16'h7FFF, 1'h1},
        '{18'h38000, 2'h0, 16'h8000, 1'h0},
        '{18'h20000, 2'h2, 16'h8000, 1'h1},
        '{18'h3D555, 2'h1, 16'hD555, 1'h0}
    };

    logic        clk_sys = 1'h0;
    logic        rst;
    logic        frame_n;
    logic        sclk;
    logic [17:0] diff_in;
    logic        diff_valid;
    logic        diff_ready;
    logic        sdo_o;
    logic        sdo_oe;
    logic        acq_mode;
    logic        conv_busy;
    logic        clip;
    logic        abort_pulse;
    int          errors     = 0;
    int          n_compared = 0;
    int          n_abort    = 0;
    int          cycles     = 0;
    int          acc        = 0;

    always #25 clk_sys = ~clk_sys;

    sarf_readout #(.IN_W(18), .DEPTH(32)) sarf_readout_i (
        .clk_sys(clk_sys), .rst(rst), .frame_n(frame_n), .sclk(sclk),
        .diff_in(diff_in), .diff_valid(diff_valid), .diff_ready(diff_ready),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .acq_mode(acq_mode), .conv_busy(conv_busy),
        .clip(clip), .abort_pulse(abort_pulse)
    );

    sarf_host sarf_host_i (
        .clk_sys(clk_sys), .frame_n(frame_n), .sclk(sclk), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .acq_mode(acq_mode), .clip(clip)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // one word into the stream, then time to be tracked
    task automatic load(input logic [17:0] v);
        @(posedge clk_sys);
        #1;
        diff_valid = 1'h1;
        diff_in    = v;
        @(posedge clk_sys);
        #1;
        diff_valid = 1'h0;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : load

    always @(posedge clk_sys) begin
        if (abort_pulse === 1'h1) n_abort <= n_abort + 1;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        rst        = 1'h1;
        diff_in    = 18'h00000;
        diff_valid = 1'h0;
        repeat (8) @(posedge clk_sys);
        #1;
        check("reset_outputs", {sdo_oe, acq_mode, conv_busy, clip, abort_pulse, diff_ready}, 32'h11);
        rst = 1'h0;
        @(posedge clk_sys);
        #1;
        check("release", {sdo_oe, acq_mode, conv_busy, clip, abort_pulse, diff_ready}, 32'h11);
        repeat (3) @(posedge clk_sys);
        #1;
        check("pre_frame", {sdo_oe, acq_mode, conv_busy, abort_pulse}, 32'h4);
        sarf_host_i.wiggle(6);
        check("idle_wiggle", {sdo_oe, acq_mode, conv_busy}, 32'h2);
        foreach (rows[i]) begin
            load(rows[i].din);
            sarf_host_i.run(rows[i].mode, 18);
            check("code", sarf_host_i.rec_word, rows[i].code);
            check("clip", sarf_host_i.rec_clip, rows[i].clp);
            check("oe_first", sarf_host_i.rec_oe[1], 1'h0);
            check("lead", {sarf_host_i.rec_oe[2], sarf_host_i.rec_bit[2]}, 2'h2);
            check("acq", {sarf_host_i.rec_acq[17], sarf_host_i.rec_acq[18]}, 2'h1);
            check("oe_after", sarf_host_i.oe_after, 1'h0);
        end
        check("no_abort", n_abort, 0);
        // short frame, then a full one on the same tracked sample
        load(18'h05A5A);
        sarf_host_i.run(1, 10);
        check("abort_oe", sarf_host_i.oe_after, 1'h0);
        check("abort_pulse", n_abort, 1);
        check("abort_bits", sarf_host_i.rec_word[15:8], 8'h5A);
        sarf_host_i.run(1, 18);
        check("after_abort", sarf_host_i.rec_word, 16'h5A5A);
        // fill the buffer while a conversion blocks draining
        fork
            sarf_host_i.run(1, 18);
            begin
                repeat (24) @(posedge clk_sys);
                #1;
                check("busy", {conv_busy, acq_mode}, 2'h2);
                diff_valid = 1'h1;
                for (int i = 0; i < 40; i++) begin
                    diff_in = 18'h00100 + 18'(i);
                    if (diff_ready === 1'h1) acc++;
                    @(posedge clk_sys);
                    #1;
                end
                diff_valid = 1'h0;
            end
        join
        check("fill_count", acc, 32);
        check("held_sample", sarf_host_i.rec_word, 16'h5A5A);
        repeat (40) @(posedge clk_sys);
        #1;
        check("drained", diff_ready, 1'h1);
        sarf_host_i.run(1, 18);
        check("drain_code", sarf_host_i.rec_word, 16'h011F);
        print_verdict();
    end
endmodule : sarf_readout_tb
`default_nettype wire
